//--- rtl/tsi_pkg.sv
// Constants, state encoding and the state record of the temperature sensor block.
// Assumes a 10 MHz system clock; all times are turned into cycle counts here.
package tsi_pkg;
  // ==========================================================
  // Timing.
  localparam int CLK_HZ = 10_000_000; // System clock rate in Hz.
  localparam int CONV_MS = 100; // Conversion period in ms.
  localparam int TOUT_MS = 75; // Least stuck-data time in ms.
  localparam int CONV_CYC = CONV_MS * (CLK_HZ / 1000); // Cycles per conversion.
  localparam int TOUT_CYC = TOUT_MS * (CLK_HZ / 1000); // Cycles of low data before release.
  // ==========================================================
  // Two-wire address, defaults and field positions.
  localparam logic [3:0] DEV_ADDR_HI = 4'h9; // Fixed upper address nibble.
  localparam logic [8:0] OSLIM_RST = 9'h0A0; // 80 degrees in half steps.
  localparam logic [8:0] HYST_RST = 9'h096; // 75 degrees in half steps.
  localparam logic [4:0] CFG_RST = 5'h00; // Comparator, active low, one fault.
  localparam logic [2:0] PTR_RST = 3'h0; // Points at the temperature.
  localparam int CFG_SD = 0; // Shutdown bit.
  localparam int CFG_INT = 1; // Interrupt mode select bit.
  localparam int CFG_POL = 2; // Active-high polarity bit.
  localparam int CFG_FQ = 3; // Fault count field, two bits.
  localparam logic [2:0] PTR_TEMP = 3'h0; // Pointer codes.
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_HYST = 3'h2;
  localparam logic [2:0] PTR_OS = 3'h3;
  // ==========================================================
  // Register bus byte offsets.
  localparam logic [7:0] A_TEMP = 8'h00; // Latest result, read only.
  localparam logic [7:0] A_CFG = 8'h04; // Configuration byte.
  localparam logic [7:0] A_HYST = 8'h08; // Hysteresis limit.
  localparam logic [7:0] A_OS = 8'h0C; // Overtemp limit.
  localparam logic [7:0] A_STAT = 8'h10; // Status, read only.
  // ==========================================================
  // Serial state machine, one-hot.
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_RX = 5'h02, S_ACK = 5'h04, S_TX = 5'h08, S_RACK = 5'h10
  } tsi_i2c_t;
  // Complete register state of the block.
  typedef struct packed {
    logic [1:0] scl_s, sda_s; // Pin synchronisers.
    logic [2:0] asel_s1, asel; // Address select synchroniser.
    logic [2:0] scl_h, sda_h; // Glitch filter history.
    logic scl_f, sda_f; // Filtered lines.
    tsi_i2c_t fsm;
    logic [3:0] bitc;
    logic [7:0] sh, msb;
    logic [2:0] idx, ptr;
    logic rw, busy, sda_oe;
    logic [15:0] rdw;
    logic [4:0] cfg;
    logic [8:0] hyst, oslim, temp;
    logic [19:0] conv_cnt, to_cnt;
    logic [2:0] qcnt;
    logic side, iflag, os_oe;
    logic hsel, hwr, one, zero;
    logic [7:0] haddr;
    logic [31:0] hrdata;
  } tsi_st_t;
endpackage

//--- rtl/tsi_top.sv
// Temperature sensor digital core: two-wire slave, conversion timer,
// fault queue with thermostat output, and an AHB-Lite register view.
// Assumes ADC_TEMP_I is a result from logic on CLK_I; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Bus access halts and restarts conversion.
// - Compare several successive results against limits.
// - Stuck low data: release, go idle.
// - No stuck timeout during shutdown.
// - Comparator: set above limit, clear below hysteresis.
// - Comparator output kept on shutdown entry.
// - Interrupt: set above limit, read clears.
// - After clear, next event is below hysteresis.
// - Interrupt output cleared on shutdown entry.
// - Defaults: comparator, 80, 75, low, pointer zero.
// - Reset loads all defaults; runs stand-alone.
// - Slave only; data line bidirectional.
// - Address 1001 plus three select pins.
// - Nine-bit two's complement, half-degree steps.
// - Temperature read only; limits writable.
// - Filter clock and data against glitches.
// - Config: shutdown, mode, polarity, fault count.
// - Fault count codes mean 1, 2, 4, 6.
// - Pointer latched; codes select four registers.
module tsi_top #(
  parameter int CONV_CYC_P = tsi_pkg::CONV_CYC, // Conversion period in cycles.
  parameter int TOUT_CYC_P = tsi_pkg::TOUT_CYC // Stuck-data timeout in cycles.
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // AHB-Lite slave.
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Two-wire bus pins and address select pins.
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic [2:0] ADDRESS_SELECT_PINS_I,
  // Converter result and open-drain over-temperature pin.
  input wire logic [8:0] ADC_TEMP_I,
  output logic OVERTEMP_O,
  output logic OVERTEMP_OE_O
);
  import tsi_pkg::*;

  // ==========================================================
  // Elaboration checks: the counters are 20 bits wide.
  if (CONV_CYC_P < 2 || CONV_CYC_P >= 2 ** 20 || TOUT_CYC_P < 2 || TOUT_CYC_P >= 2 ** 20) begin : g_bad
    $error("tsi_top: cycle count out of range.");
  end

  tsi_st_t r; // Registered state.
  tsi_st_t n; // Next state.
  logic scl_r, scl_fl, start, stop; // Filtered line events.
  logic done; // A conversion finished this cycle.
  logic qual; // Result meets the limit being watched.
  logic trip; // Fault queue full: output event.
  logic rdclr; // Read transfer addressed to this device.
  logic sd_entry; // Shutdown bit rising.

  // Fault count decode.
  function automatic logic [2:0] fq_need(input logic [1:0] c);
    case (c)
      2'h0: return 3'h1;
      2'h1: return 3'h2;
      2'h2: return 3'h4;
      default: return 3'h6;
    endcase
  endfunction

  // Two-byte read word for a pointer code; unused codes read zero.
  function automatic logic [15:0] rd_word(input tsi_st_t s);
    case (s.ptr)
      PTR_TEMP: return {s.temp, 7'h00};
      PTR_CFG: return {3'h0, s.cfg, 8'h00};
      PTR_HYST: return {s.hyst, 7'h00};
      PTR_OS: return {s.oslim, 7'h00};
      default: return 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // Next-state logic.
  always_comb begin
    n = r;
    // Two flops per pin, then a three-sample filter; a line only moves
    // when three samples agree, which rejects pulses under 200 ns.
    n.scl_s = {r.scl_s[0], SCL_I};
    n.sda_s = {r.sda_s[0], SDA_I};
    n.asel_s1 = ADDRESS_SELECT_PINS_I;
    n.asel = r.asel_s1;
    n.scl_h = {r.scl_h[1:0], r.scl_s[1]};
    n.sda_h = {r.sda_h[1:0], r.sda_s[1]};
    if (&r.scl_h) n.scl_f = 1'b1;
    else if (~|r.scl_h) n.scl_f = 1'b0;
    if (&r.sda_h) n.sda_f = 1'b1;
    else if (~|r.sda_h) n.sda_f = 1'b0;
    scl_r = !r.scl_f && n.scl_f;
    scl_fl = r.scl_f && !n.scl_f;
    start = r.scl_f && n.scl_f && r.sda_f && !n.sda_f;
    stop = r.scl_f && n.scl_f && !r.sda_f && n.sda_f;
    rdclr = 1'b0;
    // Serial slave; it never drives the clock line.
    if (start) begin
      n.fsm = S_RX;
      n.bitc = 4'h0;
      n.idx = 3'h0;
      n.busy = 1'b1;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.fsm = S_IDLE;
      n.busy = 1'b0;
      n.sda_oe = 1'b0;
    end else begin
      case (r.fsm)
        S_RX: begin
          if (scl_r) begin
            n.sh = {r.sh[6:0], n.sda_f};
            n.bitc = r.bitc + 4'h1;
          end else if (scl_fl && r.bitc == 4'h8) begin
            n.bitc = 4'h0;
            n.fsm = S_ACK;
            n.sda_oe = 1'b1;
            if (r.idx != 3'h7) n.idx = r.idx + 3'h1;
            if (r.idx == 3'h0) begin
              if (r.sh[7:1] == {DEV_ADDR_HI, r.asel}) begin
                n.rw = r.sh[0];
                n.rdw = rd_word(r);
                rdclr = r.sh[0];
              end else begin
                n.fsm = S_IDLE; // Not ours: no acknowledge.
                n.sda_oe = 1'b0;
              end
            end else if (r.idx == 3'h1) begin
              n.ptr = r.sh[2:0];
            end else if (r.ptr == PTR_CFG && r.idx == 3'h2) begin
              n.cfg = r.sh[4:0];
            end else if (r.idx == 3'h2) begin
              n.msb = r.sh;
            end else if (r.idx == 3'h3 && r.ptr == PTR_HYST) begin
              n.hyst = {r.msb, r.sh[7]};
            end else if (r.idx == 3'h3 && r.ptr == PTR_OS) begin
              n.oslim = {r.msb, r.sh[7]};
            end
          end
        end
        S_ACK: begin
          if (scl_fl) begin
            n.fsm = r.rw ? S_TX : S_RX;
            n.sda_oe = r.rw && !r.rdw[15];
            n.bitc = 4'h1;
            if (!r.rw) n.bitc = 4'h0;
          end
        end
        S_TX: begin
          // Data changes on the falling clock, MSB first.
          if (scl_fl && r.bitc == 4'h8) begin
            n.fsm = S_RACK;
            n.sda_oe = 1'b0;
          end else if (scl_fl) begin
            n.rdw = {r.rdw[14:0], 1'b0};
            n.sda_oe = !r.rdw[14];
            n.bitc = r.bitc + 4'h1;
          end
        end
        S_RACK: begin
          // A high data bit from the master ends the read.
          if (scl_r && n.sda_f) begin
            n.fsm = S_IDLE;
          end else if (scl_fl) begin
            n.fsm = S_TX;
            n.rdw = {r.rdw[14:0], 1'b0};
            n.sda_oe = !r.rdw[14];
            n.bitc = 4'h1;
          end
        end
        default: n.fsm = S_IDLE;
      endcase
    end
    // Stuck-data watchdog; stopped in shutdown to save its counter power.
    if (r.cfg[CFG_SD] || r.sda_f) n.to_cnt = 20'h00000;
    else n.to_cnt = r.to_cnt + 20'h00001;
    if (r.to_cnt == 20'(TOUT_CYC_P - 1)) begin
      n.to_cnt = 20'h00000;
      n.fsm = S_IDLE;
      n.busy = 1'b0;
      n.sda_oe = 1'b0;
    end
    // Register bus: zero wait states, always OKAY.
    if (HREADY_I) begin
      n.hsel = HSEL_I && HTRANS_I[1];
      n.hwr = HWRITE_I;
      n.haddr = HADDR_I[7:0];
    end
    if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      case (HADDR_I[7:0])
        A_TEMP: n.hrdata = {23'h0, r.temp};
        A_CFG: n.hrdata = {27'h0, r.cfg};
        A_HYST: n.hrdata = {23'h0, r.hyst};
        A_OS: n.hrdata = {23'h0, r.oslim};
        A_STAT: n.hrdata = {26'h0, r.ptr, r.busy, r.iflag, r.side};
        default: n.hrdata = 32'h0;
      endcase
    end
    if (r.hsel && r.hwr) begin
      case (r.haddr)
        A_CFG: n.cfg = HWDATA_I[4:0];
        A_HYST: n.hyst = HWDATA_I[8:0];
        A_OS: n.oslim = HWDATA_I[8:0];
        default: ; // Read-only or unmapped: ignored.
      endcase
    end
    // Conversion timer; held at zero while busy so it restarts afterwards.
    done = 1'b0;
    if (r.cfg[CFG_SD] || r.busy) begin
      n.conv_cnt = 20'h00000;
    end else if (r.conv_cnt == 20'(CONV_CYC_P - 1)) begin
      n.conv_cnt = 20'h00000;
      n.temp = ADC_TEMP_I;
      done = 1'b1;
    end else begin
      n.conv_cnt = r.conv_cnt + 20'h00001;
    end
    // Limit check on signed values; side 0 watches the overtemp limit.
    if (r.side) qual = $signed(ADC_TEMP_I) < $signed(r.hyst);
    else qual = $signed(ADC_TEMP_I) > $signed(r.oslim);
    trip = 1'b0;
    // In interrupt mode a pending event freezes the queue until cleared.
    if (done && !(r.cfg[CFG_INT] && r.iflag)) begin
      if (!qual) begin
        n.qcnt = 3'h0;
      end else if (r.qcnt + 3'h1 >= fq_need(r.cfg[CFG_FQ +: 2])) begin
        trip = 1'b1;
        n.qcnt = 3'h0;
      end else begin
        n.qcnt = r.qcnt + 3'h1;
      end
    end
    // Clears first, so a trip in the same cycle wins.
    sd_entry = n.cfg[CFG_SD] && !r.cfg[CFG_SD];
    if (rdclr) n.iflag = 1'b0;
    if (sd_entry && n.cfg[CFG_INT]) n.iflag = 1'b0;
    if (trip) begin
      n.side = !r.side;
      if (r.cfg[CFG_INT]) n.iflag = 1'b1;
    end
    // Pin pulled low when the polarity-adjusted state says so.
    n.os_oe = (r.cfg[CFG_INT] ? r.iflag : r.side) ^ r.cfg[CFG_POL];
  end

  // ==========================================================
  // State register; every field takes a constant at reset.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      r <= '0;
      r.scl_s <= 2'h3;
      r.sda_s <= 2'h3;
      r.scl_h <= 3'h7;
      r.sda_h <= 3'h7;
      r.scl_f <= 1'b1;
      r.sda_f <= 1'b1;
      r.fsm <= S_IDLE;
      r.ptr <= PTR_RST;
      r.cfg <= CFG_RST;
      r.hyst <= HYST_RST;
      r.oslim <= OSLIM_RST;
      r.one <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign HRDATA_O = r.hrdata;
  assign HREADYOUT_O = r.one;
  assign HRESP_O = r.zero;
  assign SDA_O = r.zero;
  assign SDA_OE_O = r.sda_oe;
  assign OVERTEMP_O = r.zero;
  assign OVERTEMP_OE_O = r.os_oe;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  a_conv_halt:
    assert property (r.busy |=> r.conv_cnt == 20'h00000 && !done) else $error("Conversion ran during access.");
  a_queue_count:
    assert property (done && !r.cfg[CFG_INT] && qual && !trip |=> r.qcnt == $past(r.qcnt) + 3'h1 && $stable(r.side))
    else $error("Fault queue did not count.");
  a_queue_reset:
    assert property (done && !qual |=> r.qcnt == 3'h0) else $error("Fault queue not reset.");
  a_tout_release:
    assert property (r.to_cnt == 20'(TOUT_CYC_P - 1) |=> r.fsm == S_IDLE && !r.sda_oe) else $error("No release.");
  a_tout_off:
    assert property (r.cfg[CFG_SD] |=> r.to_cnt == 20'h00000) else $error("Timeout ran in shutdown.");
  a_side_cause:
    assert property (!$stable(r.side) |-> $past(done && qual)) else $error("Output moved without cause.");
  a_sd_keep:
    assert property (sd_entry && !n.cfg[CFG_INT] && !trip |=> $stable(r.side)) else $error("Shutdown moved output.");
  a_read_clear:
    assert property (rdclr && !trip |=> !r.iflag) else $error("Read did not clear.");
  a_sd_clear:
    assert property (sd_entry && n.cfg[CFG_INT] && !trip |=> !r.iflag) else $error("Shutdown did not clear.");
  a_sda_role:
    assert property (r.sda_oe |-> r.fsm == S_ACK || r.fsm == S_TX) else $error("Data driven out of turn.");
  a_filter:
    assert property (!$stable(r.scl_f) |-> $past(r.scl_h == 3'h7 || r.scl_h == 3'h0)) else $error("Glitch passed.");
  a_pin_pol:
    assert property (!r.cfg[CFG_INT] && !r.cfg[CFG_POL] && r.side ##1 $stable(r.cfg) |-> r.os_oe)
    else $error("Pin not pulled when active.");
endmodule // tsi_top
`default_nettype wire

//--- tb/tsi_i2c_master.sv
// Behavioural two-wire bus master that drives the sensor's serial pins.
// Assumes pull-ups on both lines; the bench resolves the data wire.
`timescale 1ns/10ps
`default_nettype none
module tsi_i2c_master (
  // Serial pins.
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  // ==========================================================
  // Bus timing: 1400 ns bits with a long low phase; the clock stands high between frames.
  // The slave moves its data line some 500 to 600 ns after it sees the clock fall, through its
  // filter, so a shorter low phase would let that change land while the clock is high.
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Start or repeated start; leaves the clock low.
  task automatic start();
    #700 sda_pull_o = 1'b0;
    #200 scl_o = 1'b1;
    #300 sda_pull_o = 1'b1;
    #300 scl_o = 1'b0;
  endtask
  // Data set mid-low, sampled late in the high phase so the slave's output has settled.
  task automatic xbit(input logic b, output logic r);
    #500 sda_pull_o = ~b;
    #400 scl_o = 1'b1;
    #300 r = sda_i;
    #200 scl_o = 1'b0;
  endtask
  // One byte, most significant bit first, then the acknowledge slot.
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(ack_in, ack);
  endtask
  // Stop condition; both lines end released.
  task automatic stop();
    #300 sda_pull_o = 1'b1;
    #200 scl_o = 1'b1;
    #300 sda_pull_o = 1'b0;
    #300;
  endtask
endmodule // tsi_i2c_master
`default_nettype wire

//--- tb/temp_sensor_i2c_thermostat_tb.sv
// Self-checking bench for the temperature sensor core.
// Assumes tsi_pkg and tsi_top; counts are shortened by parameters.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; $display("Error at %0t ns: got %h expected %h", $time, (a), (e)); end end
module temp_sensor_i2c_thermostat_tb;
  import tsi_pkg::*;
  localparam int CONV = 50; // Shortened conversion period.
  localparam int TOUT = 200; // Shortened stuck-data timeout.
  logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, sda_o, sda_oe, ot_o, ot_oe, scl, pull, sda, ak;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] asel = 3'h0;
  logic [8:0] adc = 9'h000, os, hy, hot, cold;
  logic [7:0] rb, rb2;
  int seed = 19815, n_errors = 0, check_count = 0, n;
  // ==========================================================
  // Clock, wire resolution and instances.
  always #50 clk = ~clk;
  assign sda = ~((sda_oe & ~sda_o) | pull); // Pull-up wins unless someone pulls low.
  tsi_i2c_master mst (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
  tsi_top #(.CONV_CYC_P(CONV), .TOUT_CYC_P(TOUT)) DUT (.CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDRESS_SELECT_PINS_I(asel), .ADC_TEMP_I(adc),
    .OVERTEMP_O(ot_o), .OVERTEMP_OE_O(ot_oe));
  // ==========================================================
  // Helpers.
  function automatic int nf(input int c);
    return (c == 0) ? 1 : c * 2;
  endfunction
  // Waits for hready with a bound so a dead slave cannot hang the bench.
  task automatic wait_rdy();
    int k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
  endtask
  // One single-word transfer; read data is taken at the data-phase edge.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (ot_oe !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic put(input logic [7:0] d);
    mst.xbyte(d, 1'b1, rb, ak);
    `CHK(ak, 1'b0)
  endtask
  // Pointer set, repeated start, two-byte read ended by a no-acknowledge.
  task automatic i2c_rd(input logic [7:0] p);
    @(posedge clk);
    #13;
    mst.start();
    put({DEV_ADDR_HI, asel, 1'b0});
    put(p);
    mst.start();
    put({DEV_ADDR_HI, asel, 1'b1});
    mst.xbyte(8'hFF, 1'b0, rb, ak);
    mst.xbyte(8'hFF, 1'b1, rb2, ak);
    mst.stop();
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 15000 cycles.
  initial begin
    #(40_000 * 100);
    n_errors++;
    end_sim();
  end
  // ==========================================================
  // Main sequence.
  initial begin
    os = 9'h040 + 9'($random(seed) & 32'h7F);
    hy = os - 9'h060; // May go negative, which exercises signed compares.
    hot = os + 9'h001 + 9'($random(seed) & 32'h7);
    cold = hy - 9'h001 - 9'($random(seed) & 32'h7);
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    asel <= 3'($random(seed));
    rdchk(A_CFG, 32'h0);
    rdchk(A_HYST, 32'h96);
    rdchk(A_OS, 32'hA0);
    rdchk(A_STAT, 32'h0);
    `CHK(rd[5:3], PTR_RST)
    `CHK(ot_oe, 1'b0)
    ahb(1'b1, A_OS, {23'h7FFFFF, os});
    ahb(1'b1, A_HYST, {23'h7FFFFF, hy});
    ahb(1'b1, A_TEMP, 32'h1FF);
    rdchk(A_OS, {23'h0, os});
    rdchk(A_HYST, {23'h0, hy});
    rdchk(A_TEMP, 32'h0);
    $display("Test registers done");
    // Each fault-count code: trip time must fall in the expected conversion window.
    for (int c = 0; c < 4; c++) begin
      ahb(1'b1, A_CFG, 32'(c << 3));
      adc <= cold;
      wait_oe(1'b0, 6 * CONV + 20);
      `CHK(ot_oe, 1'b0)
      adc <= hot;
      wait_oe(1'b1, 6 * CONV + 20);
      `CHK(ot_oe, 1'b1)
      `CHK(n > (nf(c) - 1) * CONV && n <= nf(c) * CONV + 20, 1'b1)
    end
    rdchk(A_TEMP, {23'h0, hot});
    ahb(1'b1, A_CFG, 32'h1C);
    wait_oe(1'b0, 5);
    `CHK(ot_oe, 1'b0)
    ahb(1'b1, A_CFG, 32'h1D);
    adc <= cold;
    repeat (3 * CONV) @(posedge clk);
    `CHK(ot_oe, 1'b0)
    ahb(1'b1, A_CFG, 32'h0);
    wait_oe(1'b0, CONV + 20);
    `CHK(ot_oe, 1'b0)
    $display("Test comparator done");
    adc <= 9'($random(seed));
    repeat (CONV + 10) @(posedge clk);
    i2c_rd({5'h0, PTR_TEMP});
    `CHK({rb, rb2}, {adc, 7'h00})
    adc <= adc ^ 9'h155;
    repeat (CONV + 20) @(posedge clk);
    rdchk(A_TEMP, {23'h0, adc});
    @(posedge clk);
    #13;
    mst.start();
    put({DEV_ADDR_HI, asel, 1'b0});
    put({5'h0, PTR_OS});
    put(os[8:1]);
    put({os[0], 7'h5A});
    mst.stop();
    rdchk(A_OS, {23'h0, os});
    `CHK(rd[31:9], 23'h0)
    ahb(1'b0, A_STAT, 32'h0);
    `CHK(rd[5:3], PTR_OS)
    mst.start();
    mst.xbyte({DEV_ADDR_HI, ~asel, 1'b0}, 1'b1, rb, ak);
    mst.stop();
    `CHK(ak, 1'b1)
    $display("Test serial done");
    // Master stalls with the clock low while the slave holds its acknowledge.
    ahb(1'b1, A_CFG, 32'h01);
    @(posedge clk);
    #13;
    mst.start();
    for (int i = 7; i >= 0; i--) begin
      mst.xbit(i == 0 ? 1'b0 : (i > 3 ? DEV_ADDR_HI[i - 4] : asel[i - 1]), ak);
    end
    repeat (2 * TOUT) @(posedge clk);
    `CHK(sda_oe, 1'b1)
    ahb(1'b1, A_CFG, 32'h0);
    n = 0;
    while (sda_oe !== 1'b0 && n < TOUT + 50) begin
      @(posedge clk);
      n++;
    end
    `CHK(sda_oe, 1'b0)
    `CHK(n >= TOUT - 10, 1'b1)
    ahb(1'b0, A_STAT, 32'h0);
    `CHK(rd[2], 1'b0)
    #13;
    mst.xbit(1'b1, ak);
    mst.stop();
    $display("Test timeout done");
    ahb(1'b1, A_CFG, 32'h02);
    adc <= hot;
    wait_oe(1'b1, CONV + 20);
    `CHK(ot_oe, 1'b1)
    i2c_rd({5'h0, PTR_CFG});
    `CHK({rb, rb2}, 16'h0200)
    wait_oe(1'b0, 20);
    `CHK(ot_oe, 1'b0)
    repeat (3 * CONV) @(posedge clk);
    `CHK(ot_oe, 1'b0)
    adc <= cold;
    wait_oe(1'b1, CONV + 20);
    `CHK(ot_oe, 1'b1)
    ahb(1'b1, A_CFG, 32'h03);
    wait_oe(1'b0, 20);
    `CHK(ot_oe, 1'b0)
    $display("Test interrupt done");
    end_sim();
  end
endmodule // temp_sensor_i2c_thermostat_tb
`default_nettype wire
